// [design/tdc_cfg.svh]
// timing constants and reset values for the trigger/disable control block
`ifndef TDC_CFG_SVH
`define TDC_CFG_SVH
`define TDC_CLK_PERIOD_NS 10
`define TDC_TRIG_DELAY_MAX_NS 10
`define TDC_TRIG_DELAY_CYC (((`TDC_TRIG_DELAY_MAX_NS / `TDC_CLK_PERIOD_NS) < 1) ? 1 : (`TDC_TRIG_DELAY_MAX_NS / `TDC_CLK_PERIOD_NS))
`define TDC_TRIG_BLANK_NS 200
`define TDC_TRIG_BLANK_CYC ((`TDC_TRIG_BLANK_NS + `TDC_CLK_PERIOD_NS - 1) / `TDC_CLK_PERIOD_NS)
`define TDC_TURN_ON_DELAY_NS 40
`define TDC_TURN_ON_CYC ((`TDC_TURN_ON_DELAY_NS + `TDC_CLK_PERIOD_NS - 1) / `TDC_CLK_PERIOD_NS)
`define TDC_DIS_ENTRY_NS 100000
`define TDC_DIS_ENTRY_CYC ((`TDC_DIS_ENTRY_NS + `TDC_CLK_PERIOD_NS - 1) / `TDC_CLK_PERIOD_NS)
`define TDC_DIS_EXIT_NS 5000
`define TDC_DIS_EXIT_CYC ((`TDC_DIS_EXIT_NS + `TDC_CLK_PERIOD_NS - 1) / `TDC_CLK_PERIOD_NS)
`define TDC_DIS_REC_NS 20000
`define TDC_DIS_REC_CYC ((`TDC_DIS_REC_NS + `TDC_CLK_PERIOD_NS - 1) / `TDC_CLK_PERIOD_NS)
`define TDC_OFF_MIN_NS 4000
`define TDC_OFF_MIN_CYC ((`TDC_OFF_MIN_NS + `TDC_CLK_PERIOD_NS - 1) / `TDC_CLK_PERIOD_NS)
`define TDC_CNT_RESET 24'h00_0000
`endif

// [design/tdc_pkg.sv]
// types for the trigger/disable control block
package tdc_pkg;
    typedef enum logic [2:0] {
        TDC_SYNC,
        TDC_WAIT_ON,
        TDC_ON_DELAY,
        TDC_ON,
        TDC_OFF,
        TDC_DISABLED,
        TDC_RECOVER
    } tdc_state_t;

    typedef struct packed {
        logic cs_on;
        logic cs_off;
        logic cs_reset;
        logic dvdt_neg;
    } tdc_cmp_t;

    typedef struct packed {
        tdc_state_t state;
        logic [1:0] trig_sync;
        tdc_cmp_t cmp_meta;
        tdc_cmp_t cmp_sync;
        logic [23:0] phase_cnt;
        logic [23:0] blank_cnt;
        logic [23:0] hi_cnt;
        logic [23:0] lo_cnt;
        logic [7:0] trig_dly;
        logic drive;
        logic disabled;
    } tdc_regs_t;
endpackage

// [design/tdc_trigger_disable.sv]
// trigger/disable control for a synchronous-rectifier gate driver
`timescale 1ns/1ns
`include "tdc_cfg.svh"
module tdc_trigger_disable
    import tdc_pkg::*;
#(
    parameter bit TRIG_ACTIVE_LOW = 1'b0,
    parameter bit DVDT_ENABLE = 1'b1,
    parameter int TRIG_DELAY_CYC = `TDC_TRIG_DELAY_CYC,
    parameter int TRIG_BLANK_CYC = `TDC_TRIG_BLANK_CYC,
    parameter int TURN_ON_CYC = `TDC_TURN_ON_CYC,
    parameter int DIS_ENTRY_CYC = `TDC_DIS_ENTRY_CYC,
    parameter int DIS_EXIT_CYC = `TDC_DIS_EXIT_CYC,
    parameter int DIS_REC_CYC = `TDC_DIS_REC_CYC,
    parameter int OFF_MIN_CYC = `TDC_OFF_MIN_CYC
) (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_trigger_disable_input,
    input wire logic i_cs_on,
    input wire logic i_cs_off,
    input wire logic i_cs_reset,
    input wire logic i_dvdt_neg,
    output logic o_gate_drive_output,
    output logic o_disable_supply_current,
    output logic o_trigger_blanking
);
    localparam logic [23:0] DLY_CYC = 24'(TRIG_DELAY_CYC - 1);
    localparam logic [23:0] BLANK_CYC = 24'(TRIG_BLANK_CYC);
    localparam logic [23:0] ON_CYC = 24'(TURN_ON_CYC);
    localparam logic [23:0] ENTRY_CYC = 24'(DIS_ENTRY_CYC);
    localparam logic [23:0] EXIT_CYC = 24'(DIS_EXIT_CYC);
    localparam logic [23:0] REC_CYC = 24'(DIS_REC_CYC);
    localparam logic [23:0] OFFMIN_CYC = 24'(OFF_MIN_CYC);

    tdc_regs_t s_reg;
    tdc_regs_t s_next;
    logic trig;
    logic trig_fire;
    logic blanking;
    logic off_min_done;

    // polarity applied after the second synchroniser stage
    assign trig = s_reg.trig_sync[1] ^ TRIG_ACTIVE_LOW;
    assign blanking = (s_reg.blank_cnt != `TDC_CNT_RESET);
    // trigger pipeline sets the documented worst-case reaction latency
    assign trig_fire = trig && (s_reg.trig_dly >= DLY_CYC[7:0]);
    assign off_min_done = (s_reg.phase_cnt >= OFFMIN_CYC);

    always_comb begin
        s_next = s_reg;
        // two-flop synchronisers on the trigger and every comparator input (i_reset is used directly)
        s_next.trig_sync = {s_reg.trig_sync[0], i_trigger_disable_input};
        s_next.cmp_meta = '{cs_on: i_cs_on, cs_off: i_cs_off, cs_reset: i_cs_reset, dvdt_neg: i_dvdt_neg};
        s_next.cmp_sync = s_reg.cmp_meta;
        if (trig && s_reg.trig_dly != 8'hff) begin
            s_next.trig_dly = s_reg.trig_dly + 8'h01;
        end else if (!trig) begin
            s_next.trig_dly = 8'h00;
        end
        if (blanking) begin
            s_next.blank_cnt = s_reg.blank_cnt - 24'h00_0001;
        end
        // disable timing runs in every state
        if (trig) begin
            s_next.lo_cnt = `TDC_CNT_RESET;
            if (s_reg.hi_cnt < ENTRY_CYC) begin
                s_next.hi_cnt = s_reg.hi_cnt + 24'h00_0001;
            end
        end else begin
            s_next.hi_cnt = `TDC_CNT_RESET;
            if (s_reg.lo_cnt < EXIT_CYC) begin
                s_next.lo_cnt = s_reg.lo_cnt + 24'h00_0001;
            end
        end
        case (s_reg.state)
            TDC_SYNC: begin
                s_next.drive = 1'b0;
                // off timer restarts whenever sense drops below reset level
                if (!s_reg.cmp_sync.cs_reset) begin
                    s_next.phase_cnt = `TDC_CNT_RESET;
                end else if (!off_min_done) begin
                    s_next.phase_cnt = s_reg.phase_cnt + 24'h00_0001;
                end
                if (off_min_done || (DVDT_ENABLE && s_reg.cmp_sync.dvdt_neg)) begin
                    s_next.state = TDC_WAIT_ON;
                end
            end
            TDC_WAIT_ON: begin
                s_next.drive = 1'b0;
                s_next.phase_cnt = `TDC_CNT_RESET;
                if (s_reg.cmp_sync.cs_on) begin
                    if (trig) begin
                        s_next.state = TDC_OFF;
                    end else begin
                        s_next.state = TDC_ON_DELAY;
                    end
                end
            end
            TDC_ON_DELAY: begin
                s_next.phase_cnt = s_reg.phase_cnt + 24'h00_0001;
                if (trig) begin
                    s_next.state = TDC_OFF;
                end else if (s_reg.phase_cnt + 24'h00_0001 >= ON_CYC) begin
                    s_next.state = TDC_ON;
                    s_next.drive = 1'b1;
                    s_next.blank_cnt = BLANK_CYC;
                end
            end
            TDC_ON: begin
                // trigger wins over sense only once blanking has elapsed
                if (!blanking && trig_fire) begin
                    s_next.drive = 1'b0;
                    s_next.state = TDC_OFF;
                end else if (s_reg.cmp_sync.cs_off) begin
                    s_next.drive = 1'b0;
                    s_next.state = TDC_OFF;
                end
            end
            TDC_OFF: begin
                // rest of the cycle runs through the body diode
                s_next.drive = 1'b0;
                s_next.phase_cnt = `TDC_CNT_RESET;
                if (s_reg.cmp_sync.cs_reset) begin
                    s_next.state = TDC_SYNC;
                end
            end
            TDC_DISABLED: begin
                s_next.drive = 1'b0;
                s_next.disabled = 1'b1;
                if (!trig && s_reg.lo_cnt + 24'h00_0001 >= EXIT_CYC) begin
                    s_next.disabled = 1'b0;
                    s_next.state = TDC_RECOVER;
                    s_next.phase_cnt = `TDC_CNT_RESET;
                end
            end
            TDC_RECOVER: begin
                s_next.drive = 1'b0;
                s_next.phase_cnt = s_reg.phase_cnt + 24'h00_0001;
                if (s_reg.phase_cnt + 24'h00_0001 >= REC_CYC) begin
                    s_next.state = TDC_SYNC;
                    s_next.phase_cnt = `TDC_CNT_RESET;
                end
            end
            default: begin
                s_next.state = TDC_SYNC;
                s_next.drive = 1'b0;
            end
        endcase
        // long high level overrides everything but reset and enters disable
        if (trig && s_reg.hi_cnt + 24'h00_0001 >= ENTRY_CYC && s_reg.state != TDC_DISABLED
            && s_reg.state != TDC_RECOVER) begin
            s_next.state = TDC_DISABLED;
            s_next.drive = 1'b0;
            s_next.disabled = 1'b1;
        end
        if (s_reg.state == TDC_RECOVER && trig && s_reg.hi_cnt + 24'h00_0001 >= ENTRY_CYC) begin
            s_next.state = TDC_DISABLED;
            s_next.disabled = 1'b1;
        end
        if (i_reset) begin
            s_next = '0;
            s_next.state = TDC_SYNC;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        s_reg <= s_next;
    end

    assign o_gate_drive_output = s_reg.drive;
    assign o_disable_supply_current = s_reg.disabled;
    assign o_trigger_blanking = blanking;
endmodule

// [test/tdc_trigger_disable_props.sv]
// concurrent checks for the trigger/disable control block
`timescale 1ns/1ns
module tdc_trigger_disable_props #(
    parameter int DIS_ENTRY_CYC = 50,
    parameter int DIS_EXIT_CYC = 20,
    parameter int DIS_REC_CYC = 20
) (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_trigger_disable_input,
    input wire logic i_cs_on,
    input wire logic i_cs_off,
    input wire logic i_cs_reset,
    input wire logic i_dvdt_neg,
    input wire logic o_gate_drive_output,
    input wire logic o_disable_supply_current,
    input wire logic o_trigger_blanking
);
    logic [23:0] hi_cnt;
    logic [23:0] lo_cnt;
    logic [23:0] since_dis;
    // pin high/low run lengths and cycles since disable mode was left
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            hi_cnt <= '0;
            lo_cnt <= '0;
            since_dis <= '0;
        end else begin
            hi_cnt <= i_trigger_disable_input ? hi_cnt + 24'h00_0001 : '0;
            lo_cnt <= i_trigger_disable_input ? '0 : lo_cnt + 24'h00_0001;
            since_dis <= o_disable_supply_current ? 24'h00_0001 : (since_dis != 0 ? since_dis + 24'h00_0001 : '0);
        end
    end
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);
    AST_DIS_DRV_LOW: assert property (o_disable_supply_current |-> !o_gate_drive_output)
        else $error("drive on in disable");
    AST_DIS_EARLY: assert property ($rose(o_disable_supply_current) |-> hi_cnt >= DIS_ENTRY_CYC)
        else $error("disable too early");
    AST_DIS_LATE: assert property (hi_cnt == DIS_ENTRY_CYC + 6 |-> o_disable_supply_current)
        else $error("disable missing");
    AST_EXIT_EARLY: assert property ($fell(o_disable_supply_current) |-> lo_cnt >= DIS_EXIT_CYC)
        else $error("exit too early");
    AST_EXIT_LATE: assert property (lo_cnt == DIS_EXIT_CYC + 6 |-> !o_disable_supply_current)
        else $error("exit missing");
    AST_RECOVER: assert property (since_dis != 0 && since_dis <= DIS_REC_CYC |-> !o_gate_drive_output)
        else $error("drive in recovery");
    AST_BLANK_AT_ON: assert property ($rose(o_gate_drive_output) |-> o_trigger_blanking)
        else $error("no blanking at turn-on");
    AST_BLANK_LEN: assert property ($rose(o_trigger_blanking)
        |-> o_trigger_blanking[*4] ##[1:3] !o_trigger_blanking) else $error("blank length");
    AST_TRIG_OFF: assert property ((i_trigger_disable_input && !o_trigger_blanking)[*6]
        |-> !o_gate_drive_output) else $error("trigger ignored");
    AST_ON_DELAY: assert property ($rose(i_cs_on) && !o_gate_drive_output |=> !o_gate_drive_output[*3])
        else $error("turn-on too fast");
    AST_CS_OFF: assert property ($rose(i_cs_off) && o_gate_drive_output && !o_trigger_blanking
        |-> ##[1:6] !o_gate_drive_output) else $error("no sense turn-off");
    COV_ON: cover property ($rose(o_gate_drive_output));
    COV_TRIG_OFF: cover property ($fell(o_gate_drive_output) && i_trigger_disable_input);
    COV_DIS: cover property ($rose(o_disable_supply_current));
endmodule
bind tdc_trigger_disable tdc_trigger_disable_props #(.DIS_ENTRY_CYC(DIS_ENTRY_CYC), .DIS_EXIT_CYC(DIS_EXIT_CYC),
    .DIS_REC_CYC(DIS_REC_CYC)) props (.*);

// [test/tdc_trig_source.sv]
// primary-side trigger source seen through a signal transformer
`timescale 1ns/1ns
module tdc_trig_source (
    input wire logic i_clk_sys,
    input wire logic i_fire,
    output logic o_trigger
);
    // the transformer output settles by the next rising edge, updated after that edge's sampling
    initial o_trigger = 1'b0;
    always @(posedge i_clk_sys) begin
        o_trigger <= i_fire;
    end
endmodule

// [test/tdc_trigger_disable_tb_top.sv]
// testbench for the trigger/disable control block
`timescale 1ns/1ns
module tdc_trigger_disable_tb_top;
    logic clk = 1'b0, rst = 1'b1, fire = 1'b0, cs_on = 1'b0, cs_off = 1'b0, cs_rst = 1'b0, dvdt = 1'b0;
    logic trig, drv, dis, blank;
    int n_errors = 0, samples_checked = 0, cyc = 0;
    initial begin
        forever #5 clk = ~clk;
    end
    tdc_trig_source src (.i_clk_sys(clk), .i_fire(fire), .o_trigger(trig));
    tdc_trigger_disable #(.DIS_ENTRY_CYC(50), .DIS_EXIT_CYC(20), .DIS_REC_CYC(20), .OFF_MIN_CYC(10),
        .TRIG_BLANK_CYC(5)) DUT (.i_clk_sys(clk), .i_reset(rst), .i_trigger_disable_input(trig),
        .i_cs_on(cs_on), .i_cs_off(cs_off), .i_cs_reset(cs_rst), .i_dvdt_neg(dvdt), .o_gate_drive_output(drv),
        .o_disable_supply_current(dis), .o_trigger_blanking(blank));
    task automatic test_done();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            test_done();
        end
    end
    task automatic chk(input string name, input logic exp, input logic got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %b seen %b", name, exp, got);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wait_drv(input logic v, input int lim);
        int k;
        k = 0;
        while (drv !== v && k < lim) begin
            step(1);
            k++;
        end
        chk("drive", v, drv);
    endtask
    // off timer run of hi cycles, then sense below turn-on threshold
    task automatic arm(input int hi);
        cs_off = 1'b0;
        cs_rst = 1'b1;
        step(hi);
        cs_rst = 1'b0;
        cs_on = 1'b1;
    endtask
    task automatic end_cycle();
        cs_on = 1'b0;
        cs_off = 1'b1;
        step(6);
        cs_off = 1'b0;
    endtask
    task automatic s_plain();
        cs_rst = 1'b1;
        step(7);
        cs_rst = 1'b0;
        step(1);
        arm(7);
        step(8);
        chk("drive", 1'b0, drv);
        cs_on = 1'b0;
        arm(14);
        wait_drv(1'b1, 10);
        chk("blank", 1'b1, blank);
        step(10);
        cs_on = 1'b0;
        cs_off = 1'b1;
        wait_drv(1'b0, 6);
        end_cycle();
    endtask
    task automatic s_blank();
        arm(14);
        wait_drv(1'b1, 10);
        fire = 1'b1;
        step(1);
        fire = 1'b0;
        step(8);
        chk("drive", 1'b1, drv);
        end_cycle();
        arm(14);
        wait_drv(1'b1, 10);
        fire = 1'b1;
        wait_drv(1'b0, 8);
        fire = 1'b0;
        step(6);
        chk("drive", 1'b0, drv);
        end_cycle();
    endtask
    task automatic s_trig();
        arm(14);
        wait_drv(1'b1, 10);
        step(8);
        fire = 1'b1;
        wait_drv(1'b0, 5);
        end_cycle();
        arm(14);
        step(8);
        chk("drive", 1'b0, drv);
        fire = 1'b0;
        end_cycle();
    endtask
    task automatic s_dis();
        fire = 1'b1;
        step(40);
        chk("disable", 1'b0, dis);
        step(20);
        chk("disable", 1'b1, dis);
        chk("drive", 1'b0, drv);
        fire = 1'b0;
        step(12);
        chk("disable", 1'b1, dis);
        step(14);
        chk("disable", 1'b0, dis);
        dvdt = 1'b1;
        cs_on = 1'b1;
        step(15);
        chk("drive", 1'b0, drv);
        wait_drv(1'b1, 15);
        dvdt = 1'b0;
        end_cycle();
    endtask
    initial begin
        step(3);
        rst = 1'b0;
        s_plain();
        s_blank();
        s_trig();
        s_dis();
        test_done();
    end
endmodule
